// ---- hw/tmwe_defines.vh ----
`ifndef TMWE_DEFINES_VH
`define TMWE_DEFINES_VH
// register word offsets (word addresses)
`define TMWE_ADDR_CONTROL_A  4'h0
`define TMWE_ADDR_SYNC_BUSY  4'h1
`define TMWE_ADDR_PERIOD     4'h2
`define TMWE_ADDR_CMPZERO    4'h3
`define TMWE_ADDR_DIRECTION  4'h4
`define TMWE_ADDR_COUNT      4'h5
// control_a field positions
`define TMWE_EN_BIT          1
`define TMWE_WIDTH_LSB       2
`define TMWE_WAVE_LSB        5
// direction field position
`define TMWE_DIR_BIT         0
// sync busy field position
`define TMWE_SB_ENABLE_BIT   1
// waveform selector codes
`define TMWE_WAVE_NORMAL_FREQ  2'h0
`define TMWE_WAVE_MATCH_FREQ   2'h1
`define TMWE_WAVE_NORMAL_PWM   2'h2
`define TMWE_WAVE_MATCH_PWM    2'h3
// width selector codes
`define TMWE_WIDTH_16        2'h0
`define TMWE_WIDTH_8         2'h1
`define TMWE_WIDTH_32        2'h2
// counter maxima
`define TMWE_MAX_8           32'h000000FF
`define TMWE_MAX_16          32'h0000FFFF
`define TMWE_MAX_32          32'hFFFFFFFF
// counter step and bottom
`define TMWE_COUNT_ZERO      32'h00000000
`define TMWE_COUNT_STEP      32'h00000001
// reset values
`define TMWE_RST_WORD        32'h00000000
`define TMWE_RST_BIT         1'h0
`define TMWE_RST_SEL         2'h0
`endif

// ---- hw/tmwe_sync_delay.v ----
`timescale 1ns/100ps
`include "tmwe_defines.vh"
// carries the written enable across a synchroniser-length delay
module tmwe_sync_delay #(
   parameter STAGES = 3
) (
   input  wire             clk,
   input  wire             rstN,
   input  wire             reqIn,
   output wire             levelOut
);
   reg  [STAGES-1:0] pipe_q;
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         pipe_q <= {STAGES{`TMWE_RST_BIT}};
      end else begin
         pipe_q <= {pipe_q[STAGES-2:0], reqIn};
      end
   end
   assign levelOut = pipe_q[STAGES-1];
endmodule // tmwe_sync_delay

// ---- hw/tmwe_timer_wave.v ----
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "tmwe_defines.vh"
module tmwe_timer_wave #(
   parameter SYNC_STAGES = 3
) (
   input  wire        core_clk,
   input  wire        arst_n,
   input  wire [3:0]  avsAddress,
   input  wire        avsRead,
   input  wire        avsWrite,
   input  wire [31:0] avsWriteData,
   input  wire [3:0]  avsByteEnable,
   output reg  [31:0] avsReadData,
   output wire        avsWaitRequest,
   output wire        timerRunning,
   output wire        waveOut,
   output wire        wrapEvent,
   output wire        matchEvent
);
   // reset and bus
   reg         rstMeta_q;
   reg         rstSync_q;
   reg         ack_q;
   // configuration registers
   reg         enable_q;
   reg  [1:0]  waveSel_q;
   reg  [1:0]  widthSel_q;
   reg         sync_busy_flags_q;
   reg         sync_busy_flags_d;
   reg         countDown_q;
   reg  [31:0] period_q;
   reg  [31:0] cmpZero_q;
   // counter and waveform
   reg  [31:0] count_q;
   reg  [31:0] count_d;
   reg         wave_q;
   reg         wave_d;
   reg         wrap;
   reg         match;
   reg  [31:0] topVal;
   wire [31:0] countMask;
   wire        runLevel;
   wire        busReq;
   wire        rdAcc;
   wire        wrTaken;
   wire        wrControl;
   wire        wrPeriod;
   wire        wrCmpZero;
   wire        wrDirection;
   wire        cfgUnlocked;
   wire        enWrite;
   wire        running;

   function [31:0] width_max;
      input [1:0] sel;
      begin
         case (sel)
            `TMWE_WIDTH_8: begin
               width_max = `TMWE_MAX_8;
            end
            `TMWE_WIDTH_32: begin
               width_max = `TMWE_MAX_32;
            end
            default: begin
               width_max = `TMWE_MAX_16;
            end
         endcase
      end
   endfunction

   // register select for one bus word
   function addr_hit;
      input [3:0] addr;
      input [3:0] slot;
      begin
         addr_hit = (addr == slot);
      end
   endfunction

   // top value for the selected operation
   function [31:0] top_value;
      input [1:0]  wave;
      input [1:0]  width;
      input [31:0] period_value;
      input [31:0] cmp;
      begin
         case (wave)
            `TMWE_WAVE_MATCH_FREQ, `TMWE_WAVE_MATCH_PWM: begin
               top_value = cmp;
            end
            default: begin
               if (width == `TMWE_WIDTH_8) begin
                  top_value = period_value;
               end else begin
                  top_value = width_max(width);
               end
            end
         endcase
      end
   endfunction

   // read multiplexer
   function [31:0] read_word;
      input [3:0] addr;
      begin
         case (addr)
            `TMWE_ADDR_CONTROL_A: begin
               read_word = {25'h0000000, waveSel_q, 1'b0, widthSel_q, enable_q, 1'b0};
            end
            `TMWE_ADDR_SYNC_BUSY: begin
               read_word = {30'h00000000, sync_busy_flags_q, 1'b0};
            end
            `TMWE_ADDR_PERIOD: begin
               read_word = period_q;
            end
            `TMWE_ADDR_CMPZERO: begin
               read_word = cmpZero_q;
            end
            `TMWE_ADDR_DIRECTION: begin
               read_word = {31'h00000000, countDown_q};
            end
            `TMWE_ADDR_COUNT: begin
               read_word = count_q;
            end
            default: begin
               read_word = `TMWE_RST_WORD;
            end
         endcase
      end
   endfunction

   // reset is released through two flops
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rstMeta_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
      end
   end

   // second flop drives every reset below
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rstSync_q <= 1'b0;
      end else begin
         rstSync_q <= rstMeta_q;
      end
   end

   // one wait cycle per access
   assign busReq         = avsRead || avsWrite;
   assign rdAcc          = avsRead && !ack_q;
   assign avsWaitRequest = busReq && !ack_q;

   // ack marks the second cycle of a request
   always @(posedge core_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         ack_q <= `TMWE_RST_BIT;
      end else begin
         ack_q <= busReq && !ack_q;
      end
   end

   // write strobes, taken at the edge where waitrequest is low
   assign wrTaken     = avsWrite && ack_q;
   assign wrControl   = wrTaken && addr_hit(avsAddress, `TMWE_ADDR_CONTROL_A) && avsByteEnable[0];
   assign wrPeriod    = wrTaken && addr_hit(avsAddress, `TMWE_ADDR_PERIOD);
   assign wrCmpZero   = wrTaken && addr_hit(avsAddress, `TMWE_ADDR_CMPZERO);
   assign wrDirection = wrTaken && addr_hit(avsAddress, `TMWE_ADDR_DIRECTION) && avsByteEnable[0];
   assign enWrite     = wrControl;
   assign cfgUnlocked = !enable_q && !running;

   // enable stays writable while running
   always @(posedge core_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         enable_q <= `TMWE_RST_BIT;
      end else if (wrControl) begin
         enable_q <= avsWriteData[`TMWE_EN_BIT];
      end
   end

   // waveform and width change only while fully stopped
   always @(posedge core_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         waveSel_q  <= `TMWE_RST_SEL;
         widthSel_q <= `TMWE_RST_SEL;
      end else if (wrControl && cfgUnlocked) begin
         waveSel_q  <= avsWriteData[`TMWE_WAVE_LSB+1:`TMWE_WAVE_LSB];
         widthSel_q <= avsWriteData[`TMWE_WIDTH_LSB+1:`TMWE_WIDTH_LSB];
      end
   end

   // period and compare channel zero values
   always @(posedge core_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         period_q <= `TMWE_RST_WORD;
      end else if (wrPeriod) begin
         period_q <= avsWriteData;
      end
   end

   always @(posedge core_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         cmpZero_q <= `TMWE_RST_WORD;
      end else if (wrCmpZero) begin
         cmpZero_q <= avsWriteData;
      end
   end

   // counting direction
   always @(posedge core_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         countDown_q <= `TMWE_RST_BIT;
      end else if (wrDirection) begin
         countDown_q <= avsWriteData[`TMWE_DIR_BIT];
      end
   end

   // enable crosses a fixed delay before the counter sees it
   tmwe_sync_delay #(
      .STAGES   (SYNC_STAGES)
   ) uEnSync (
      .clk      (core_clk),
      .rstN     (rstSync_q),
      .reqIn    (enable_q),
      .levelOut (runLevel)
   );

   assign running      = runLevel;
   assign timerRunning = running;

   // busy from write until the delayed level matches the written value
   always @* begin
      sync_busy_flags_d = sync_busy_flags_q;
      if (enWrite) begin
         sync_busy_flags_d = 1'b1;
      end else if (runLevel == enable_q) begin
         sync_busy_flags_d = 1'b0;
      end
   end

   always @(posedge core_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         sync_busy_flags_q <= `TMWE_RST_BIT;
      end else begin
         sync_busy_flags_q <= sync_busy_flags_d;
      end
   end

   // top value in use
   always @* begin
      topVal = top_value(waveSel_q, widthSel_q, period_q, cmpZero_q);
   end

   assign countMask = width_max(widthSel_q);

   // counter step and wraparound at the selected top
   always @* begin
      wrap    = 1'b0;
      count_d = count_q;
      if (running) begin
         if (countDown_q) begin
            wrap    = (count_q == `TMWE_COUNT_ZERO);
            count_d = wrap ? topVal : count_q - `TMWE_COUNT_STEP;
         end else begin
            wrap    = (count_q >= topVal);
            count_d = wrap ? `TMWE_COUNT_ZERO : count_q + `TMWE_COUNT_STEP;
         end
      end
   end

   // compare channel zero match
   always @* begin
      match = 1'b0;
      if (running) begin
         match = (count_q == cmpZero_q);
      end
   end

   // waveform output on match and wraparound
   always @* begin
      wave_d = wave_q;
      if (running) begin
         case (waveSel_q)
            `TMWE_WAVE_NORMAL_FREQ, `TMWE_WAVE_MATCH_FREQ: begin
               if (match) begin
                  wave_d = !wave_q;
               end
            end
            default: begin
               if (wrap) begin
                  wave_d = !countDown_q;
               end else if (match) begin
                  wave_d = countDown_q;
               end
            end
         endcase
      end
   end

   // counter register, kept inside the selected width
   always @(posedge core_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         count_q <= `TMWE_RST_WORD;
      end else begin
         count_q <= count_d & countMask;
      end
   end

   // waveform register
   always @(posedge core_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         wave_q <= `TMWE_RST_BIT;
      end else begin
         wave_q <= wave_d;
      end
   end

   // event pulses while running
   assign waveOut    = wave_q;
   assign wrapEvent  = wrap;
   assign matchEvent = match;

   // read data loaded in the wait cycle, stands until the next read
   always @(posedge core_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         avsReadData <= `TMWE_RST_WORD;
      end else if (rdAcc) begin
         avsReadData <= read_word(avsAddress);
      end
   end
endmodule // tmwe_timer_wave

// ---- tb/tmwe_timer_wave_checker.sv ----
`timescale 1ns/100ps
module tmwe_timer_wave_checker #(
   parameter SYNC_STAGES = 3
) (
   input wire logic        core_clk,
   input wire logic        arst_n,
   input wire logic [3:0]  avsAddress,
   input wire logic        avsRead,
   input wire logic        avsWrite,
   input wire logic [31:0] avsWriteData,
   input wire logic [3:0]  avsByteEnable,
   input wire logic [31:0] avsReadData,
   input wire logic        avsWaitRequest,
   input wire logic        timerRunning,
   input wire logic        waveOut,
   input wire logic        wrapEvent,
   input wire logic        matchEvent
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   sequence sCtrlWr;
      avsWrite && !avsWaitRequest && avsAddress == 4'h0 && avsByteEnable[0];
   endsequence
   sequence sEnWr;
      !timerRunning ##0 sCtrlWr ##0 avsWriteData[1];
   endsequence
   sequence sDisWr;
      timerRunning ##0 sCtrlWr ##0 !avsWriteData[1];
   endsequence
   AST_WAIT_RISE: assert property ($rose(avsRead || avsWrite) |-> avsWaitRequest) else $error("no wait cycle");
   AST_ONE_WAIT: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest) else $error("long wait");
   AST_IDLE_NOWAIT: assert property (!(avsRead || avsWrite) |-> !avsWaitRequest) else $error("idle wait");
   AST_START_DELAY: assert property (sEnWr |=> !timerRunning ##[1:8] timerRunning) else $error("start timing");
   AST_STOP_DELAY: assert property (sDisWr |=> timerRunning ##[1:8] !timerRunning) else $error("stop timing");
   AST_IDLE_EVENTS: assert property (!timerRunning |-> !wrapEvent && !matchEvent) else $error("event while off");
   AST_WAVE_HOLD: assert property (timerRunning && !wrapEvent && !matchEvent ##1 timerRunning
      |-> $stable(waveOut)) else $error("wave moved");
   AST_RD_STAND: assert property (!avsRead ##1 !avsRead |-> $stable(avsReadData)) else $error("read data moved");
endmodule // tmwe_timer_wave_checker
bind tmwe_timer_wave tmwe_timer_wave_checker #(.SYNC_STAGES(SYNC_STAGES)) i_chk (.core_clk(core_clk),
   .arst_n(arst_n), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
   .avsByteEnable(avsByteEnable), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
   .timerRunning(timerRunning), .waveOut(waveOut), .wrapEvent(wrapEvent), .matchEvent(matchEvent));

// ---- tb/tmwe_timer_wave_test.sv ----
`timescale 1ns/100ps
module tmwe_timer_wave_test;
   logic        core_clk, arst_n, avsRead, avsWrite, avsWaitRequest, timerRunning, waveOut, wrapEvent, matchEvent;
   logic [3:0]  avsAddress, avsByteEnable;
   logic [31:0] avsWriteData, avsReadData, q, v;
   int          n_mismatch = 0, compares = 0, cyc = 0;
   tmwe_timer_wave #(.SYNC_STAGES(3)) i_dut (.core_clk(core_clk), .arst_n(arst_n), .avsAddress(avsAddress),
      .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
      .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .timerRunning(timerRunning),
      .waveOut(waveOut), .wrapEvent(wrapEvent), .matchEvent(matchEvent));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   task give_verdict;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one avalon transfer, request held until waitrequest seen low at an edge
   task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avsAddress <= a;
      avsWriteData <= d;
      avsWrite <= w;
      avsRead <= !w;
      do @(posedge core_clk); while (avsWaitRequest !== 1'b0);
      q = avsReadData;
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
   endtask
   // poll the enable busy flag until it drops
   task settle;
      for (int k = 0; k < 20; k++) begin
         acc(1'b0, 4'h1, 32'h0);
         if (q[1] === 1'b0)
            break;
      end
      chk("busy", 32'h0, {31'h0, q[1]});
   endtask
   task gap(input int e);
      int n;
      do @(negedge core_clk); while (wrapEvent !== 1'b1);
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (wrapEvent !== 1'b1 && n < 100);
      chk("wrap gap", e, n);
      @(negedge core_clk);
   endtask
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_mismatch++;
         give_verdict;
      end
   end
   initial begin
      arst_n = 1'b0;
      avsRead = 1'b0;
      avsWrite = 1'b0;
      avsAddress = 4'h0;
      avsWriteData = 32'h0;
      avsByteEnable = 4'hF;
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      acc(1'b0, 4'h0, 32'h0);
      chk("control_a reset", 32'h0, q);
      for (int i = 0; i < 4; i++) begin
         v = {25'h0, i[1:0], 1'b0, i[1:0], 2'h0};
         acc(1'b1, 4'h0, v);
         acc(1'b0, 4'h0, 32'h0);
         chk("control_a fields", v, q);
      end
      acc(1'b1, 4'h3, 32'h4);
      acc(1'b1, 4'h2, 32'h6);
      acc(1'b1, 4'h0, 32'h26);
      acc(1'b0, 4'h1, 32'h0);
      chk("busy set", 32'h2, q & 32'h2);
      acc(1'b0, 4'h0, 32'h0);
      chk("enable readback", 32'h26, q);
      settle;
      chk("running", 32'h1, {31'h0, timerRunning});
      gap(5);
      acc(1'b1, 4'h0, 32'h4A);
      acc(1'b0, 4'h0, 32'h0);
      chk("locked fields", 32'h26, q);
      acc(1'b1, 4'h0, 32'h24);
      settle;
      chk("stopped", 32'h0, {31'h0, timerRunning});
      acc(1'b1, 4'h0, 32'h06);
      settle;
      gap(7);
      acc(1'b1, 4'h0, 32'h04);
      settle;
      acc(1'b1, 4'h0, 32'h46);
      settle;
      gap(7);
      chk("pwm wrap sets", 32'h1, {31'h0, waveOut});
      acc(1'b1, 4'h4, 32'h1);
      gap(7);
      chk("pwm wrap clears down", 32'h0, {31'h0, waveOut});
      do @(negedge core_clk); while (matchEvent !== 1'b1);
      @(negedge core_clk);
      chk("pwm match sets down", 32'h1, {31'h0, waveOut});
      @(posedge core_clk);
      acc(1'b1, 4'hF, 32'hFFFFFFFF);
      acc(1'b0, 4'hF, 32'h0);
      chk("unmapped", 32'h0, q);
      give_verdict;
   end
endmodule // tmwe_timer_wave_test
